// ===== verilog/acif_pkg.sv
// acif_pkg: register map, field positions and carrier types of the converter control block
// assumes a byte-wide special-function register port driven by the cpu core
package acif_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam int NUM_CH = 4;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'hd9;
    localparam logic [7:0] ADDR_CHAN_CTRL = 8'hda;
    localparam logic [7:0] ADDR_RES_HIGH = 8'hdb;
    localparam logic [7:0] ADDR_RES_LOW = 8'hdc;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_DONE = 4;
    localparam int HIGH_LSB = 2;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_LOW = 2'h0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acif_sfr_req_s;

    typedef struct packed {
        logic start;
        logic abort;
        logic [NUM_CH-1:0] chan;
    } acif_core_cmd_s;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } acif_conv_e;
endpackage

// ===== verilog/acif_sync.sv
// acif_sync: three-stage synchroniser with agreement of the last two stages
// assumes the input arrives from outside the I_CLK domain
`timescale 1ns/1ps
`default_nettype none
module acif_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            o_sync <= '0;
        end
        else
        begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            // per bit: take a change only once stages two and three agree
            o_sync <= (s2 & s3) | (o_sync & (s2 | s3));
        end
    end
endmodule
`default_nettype wire

// ===== verilog/acif_top.sv
// acif_top: control and register interface of a 4-channel 10-bit sar converter
// assumes a byte sfr port from the cpu, idle and stop power-mode levels, and an analog core
// that returns a result word with a done pulse on the same clock (used unsynchronised)
`timescale 1ns/1ps
`default_nettype none
module acif_top
    import acif_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [ADDR_W-1:0] i_sfr_addr,
    input wire logic [DATA_W-1:0] i_sfr_wdata,
    output logic [DATA_W-1:0] o_sfr_rdata,
    output logic o_sfr_hit,
    input wire logic i_idle_mode,
    input wire logic i_stop_mode,
    input wire logic i_core_done,
    input wire logic [RES_W-1:0] i_core_result,
    output logic o_core_start,
    output logic o_core_abort,
    output logic o_core_power,
    output logic [CH-1:0] o_core_chan,
    output logic [CH-1:0] o_analog_pin_en
);
    typedef struct packed {
        acif_conv_e state;
        logic [CH-1:0] pin_en;
        logic enable;
        logic done;
        logic [CH-1:0] chan_sel;
        logic [DATA_W-1:0] res_high;
        logic [1:0] res_low;
        logic [DATA_W-1:0] rdata;
        logic start;
        logic abort;
        logic [CH-1:0] core_chan;
    } acif_state_s;

    acif_state_s r;
    acif_state_s next_r;
    acif_sfr_req_s req;
    acif_core_cmd_s cmd;
    logic [1:0] mode_sync;
    logic low_power;
    logic core_done;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        addr_is = (a == b);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = addr_is(a, ADDR_PIN_FUNC) | addr_is(a, ADDR_CHAN_CTRL)
            | addr_is(a, ADDR_RES_HIGH) | addr_is(a, ADDR_RES_LOW);
    endfunction

    // power-mode levels come from the cpu clock gating logic, treat as foreign
    acif_sync #(
        .WIDTH(2)
    ) u_mode_sync (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_async({i_stop_mode, i_idle_mode}),
        .o_sync(mode_sync)
    );

    assign low_power = |mode_sync;
    assign req = '{wr: i_sfr_wr, rd: i_sfr_rd, addr: i_sfr_addr, wdata: i_sfr_wdata};
    // done pulse is same-clock logic of the analog core wrapper
    assign core_done = i_core_done;

    always_comb
    begin
        next_r = r;
        next_r.start = 1'b0;
        next_r.abort = 1'b0;
        // register writes
        if (req.wr)
        begin
            if (addr_is(req.addr, ADDR_PIN_FUNC))
            begin
                next_r.pin_en = req.wdata[CH-1:0];
            end
            if (addr_is(req.addr, ADDR_CHAN_CTRL))
            begin
                next_r.enable = req.wdata[BIT_ENABLE];
                next_r.chan_sel = req.wdata[CH-1:0];
                next_r.done = req.wdata[BIT_DONE];
            end
            if (addr_is(req.addr, ADDR_RES_HIGH))
            begin
                next_r.res_high = req.wdata;
            end
            if (addr_is(req.addr, ADDR_RES_LOW))
            begin
                next_r.res_low = req.wdata[1:0];
            end
        end
        // conversion sequencer
        unique case (r.state)
            ST_OFF:
            begin
                if (!low_power)
                begin
                    next_r.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (low_power)
                begin
                    next_r.state = ST_OFF;
                end
                else if (r.enable)
                begin
                    // channel is latched with start, so select before enable
                    next_r.start = 1'b1;
                    next_r.core_chan = r.chan_sel & r.pin_en;
                    next_r.state = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (low_power)
                begin
                    // results untouched on abort
                    next_r.abort = 1'b1;
                    next_r.state = ST_OFF;
                end
                else if (core_done)
                begin
                    next_r.res_high = i_core_result[RES_W-1:HIGH_LSB];
                    next_r.res_low = i_core_result[HIGH_LSB-1:0];
                    next_r.done = 1'b1;
                    next_r.state = ST_WAIT;
                end
                else if (!r.enable)
                begin
                    next_r.abort = 1'b1;
                    next_r.state = ST_WAIT;
                end
            end
            default:
            begin
                next_r.state = ST_OFF;
            end
        endcase
        // read data, reserved bits as zero
        next_r.rdata = RST_BYTE;
        if (req.rd)
        begin
            if (addr_is(req.addr, ADDR_PIN_FUNC))
            begin
                next_r.rdata[CH-1:0] = r.pin_en;
            end
            if (addr_is(req.addr, ADDR_CHAN_CTRL))
            begin
                next_r.rdata[BIT_ENABLE] = r.enable;
                next_r.rdata[BIT_DONE] = r.done;
                next_r.rdata[CH-1:0] = r.chan_sel;
            end
            if (addr_is(req.addr, ADDR_RES_HIGH))
            begin
                next_r.rdata = r.res_high;
            end
            if (addr_is(req.addr, ADDR_RES_LOW))
            begin
                next_r.rdata[1:0] = r.res_low;
            end
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            r.state <= ST_OFF;
            r.pin_en <= RST_NIBBLE;
            r.enable <= 1'b0;
            r.done <= 1'b0;
            r.chan_sel <= RST_NIBBLE;
            r.res_high <= RST_BYTE;
            r.res_low <= RST_LOW;
            r.rdata <= RST_BYTE;
            r.start <= 1'b0;
            r.abort <= 1'b0;
            r.core_chan <= RST_NIBBLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign cmd = '{start: r.start, abort: r.abort, chan: r.core_chan};
    assign o_sfr_rdata = r.rdata;
    assign o_sfr_hit = mapped(req.addr) & (req.rd | req.wr);
    assign o_core_start = cmd.start;
    assign o_core_abort = cmd.abort;
    assign o_core_chan = cmd.chan;
    assign o_core_power = (r.state != ST_OFF);
    // cleared bit gives pin back to port or pwm mux
    assign o_analog_pin_en = r.pin_en;
endmodule
`default_nettype wire

// ===== verification/acif_props.sv
// acif_props: port-level checks of the converter control block
// assumes bound into acif_top, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module acif_props
    import acif_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [ADDR_W-1:0] i_sfr_addr,
    input wire logic [DATA_W-1:0] i_sfr_wdata,
    input wire logic [DATA_W-1:0] o_sfr_rdata,
    input wire logic o_sfr_hit,
    input wire logic i_idle_mode,
    input wire logic i_stop_mode,
    input wire logic o_core_start,
    input wire logic o_core_power,
    input wire logic [CH-1:0] o_core_chan,
    input wire logic [CH-1:0] o_analog_pin_en
);
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    wire logic mapped = i_sfr_addr >= ADDR_PIN_FUNC && i_sfr_addr <= ADDR_RES_LOW;
    wire logic pin_wr = i_sfr_wr && i_sfr_addr == ADDR_PIN_FUNC;
    property p_hit; o_sfr_hit == ((i_sfr_rd || i_sfr_wr) && mapped); endproperty
    a_hit: assert property (p_hit) else $error("hit flag wrong");
    property p_unmap; i_sfr_rd && !mapped |=> o_sfr_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pin; pin_wr |=> o_analog_pin_en == $past(i_sfr_wdata[CH-1:0]); endproperty
    a_pin: assert property (p_pin) else $error("pin enables not written");
    property p_pin_hold; !pin_wr |=> $stable(o_analog_pin_en); endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin enables moved");
    property p_rd_pin;
        i_sfr_rd && i_sfr_addr == ADDR_PIN_FUNC |=> o_sfr_rdata == 8'($past(o_analog_pin_en));
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("pin register readback");
    property p_start_pwr; o_core_start |-> o_core_power; endproperty
    a_start_pwr: assert property (p_start_pwr) else $error("start while off");
    property p_low_pwr; (i_idle_mode || i_stop_mode) [*8] |-> !o_core_power; endproperty
    a_low_pwr: assert property (p_low_pwr) else $error("power kept in low power");
    property p_chan; o_core_start |-> (o_core_chan & ~o_analog_pin_en) == '0; endproperty
    a_chan: assert property (p_chan) else $error("channel not analog pin");
endmodule
bind acif_top acif_props #(.CH(CH)) u_props (.I_CLK, .I_SYS_RST, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .o_sfr_hit, .i_idle_mode, .i_stop_mode,
    .o_core_start, .o_core_power, .o_core_chan, .o_analog_pin_en);
`default_nettype wire

// ===== verification/acif_core_model.sv
// acif_core_model: analog core, answers a start after i_lat cycles
// assumes start and abort are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module acif_core_model
    import acif_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [7:0] i_lat,
    input wire logic [RES_W-1:0] i_val,
    output logic o_done = 1'b0,
    output logic [RES_W-1:0] o_result
);
    int cnt = 0;
    // word only valid with done, so a late sample sees garbage
    assign o_result = o_done ? i_val : ~i_val;
    always @(posedge i_clk)
    begin
        o_done <= cnt == 1;
        if (i_start || i_abort)
            cnt <= i_abort ? 0 : int'(i_lat);
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// ===== verification/acif_top_test.sv
// acif_top_test: register-level regression of the converter control block
// assumes acif_core_model stands in for the analog core
`timescale 1ns/1ps
`default_nettype none
module acif_top_test
    import acif_pkg::*;
;
    logic clk = 0, rst = 1, wr = 0, rd = 0, idle = 0, stop = 0, rd_q = 0;
    logic [7:0] addr = 0, wdata = 0, lat = 4, rdata;
    logic [9:0] val = 0, res, old;
    logic [3:0] pin, chan;
    logic done, hit, start, abort, power;
    logic [31:0] seed = 32'hed0a04d5;
    logic [7:0] q[$];
    int n_fail = 0, checks = 0, cyc = 0, aborts = 0, n0 = 0;
    acif_top dut (.I_CLK(clk), .I_SYS_RST(rst), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .i_idle_mode(idle), .i_stop_mode(stop), .i_core_done(done), .i_core_result(res),
        .o_core_start(start), .o_core_abort(abort), .o_core_power(power),
        .o_core_chan(chan), .o_analog_pin_en(pin));
    acif_core_model core (.i_clk(clk), .i_start(start), .i_abort(abort), .i_lat(lat),
        .i_val(val), .o_done(done), .o_result(res));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one access then an idle edge, so strobes never toggle twice in a step
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w)
            q.push_back(d);
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        @(posedge clk);
    endtask
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 4000)
        begin
            n_fail++;
            end_sim();
        end
        else
        begin
            if (rd_q)
                check(10'(rdata), 10'(q.pop_front()));
            // abort is a one-cycle pulse, so each one is counted once
            if (abort)
                aborts++;
            rd_q <= rd;
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int a = 'hd8; a <= 'hdd; a++)
            acc(0, 8'(a), 8'h00);
        $display("test reset done");
        acc(1, 8'hd9, 8'hff);
        acc(0, 8'hd9, 8'h0f);
        check(10'(pin), 10'hf);
        for (int c = 0; c < 4; c++)
        begin
            seed = lfsr(seed);
            val <= seed[9:0];
            acc(1, 8'hda, 8'(1 << c));
            acc(1, 8'hda, 8'h80 | 8'(1 << c));
            repeat (20) @(posedge clk);
            check(10'(chan), 10'(1 << c));
            acc(0, 8'hda, 8'h90 | 8'(1 << c));
            acc(0, 8'hdb, seed[9:2]);
            acc(0, 8'hdc, {6'h0, seed[1:0]});
        end
        $display("test convert done");
        acc(1, 8'hda, 8'h01);
        old = val;
        lat <= 200;
        // neither the valid word nor the invalid one equals old
        val <= old ^ 10'h2aa;
        acc(1, 8'hda, 8'h81);
        for (int m = 0; m < 2; m++)
        begin
            n0 = aborts;
            repeat (10) @(posedge clk);
            {idle, stop} <= 2'(m + 1);
            repeat (20) @(posedge clk);
            check(10'(power), 10'h0);
            check(10'(aborts - n0), 10'h1);
            acc(0, 8'hdb, old[9:2]);
            acc(0, 8'hdc, {6'h0, old[1:0]});
            {idle, stop} <= 2'b00;
        end
        $display("test abort done");
        acc(1, 8'hd9, 8'h00);
        check(10'(pin), 10'h0);
        // conversion restarts with its pin now digital, so nothing is routed
        repeat (10) @(posedge clk);
        check(10'(chan), 10'h0);
        $display("test pin done");
        end_sim();
    end
endmodule
`default_nettype wire
